// ### shared/fmsi_map.svh
/*
 Offsets, field positions, reset values and counts of the framer master
 status and interrupt block. Assumes inclusion by bare name from the
 package and the design modules.
 // Function
 // - Overflow summary 1 while a counter saturates; counter clear drops it.
 // - Sub-block summary is 1 while a latched bit and its enable are set.
 // - Sub-block summary drops once latched bits or enables are cleared.
 // - Summary bit raises interrupt only with its enable; drops otherwise.
 // - Transmit clock loss sets after no toggle for 9 to 21 periods.
 // - Receive clock loss sets after no toggle for 9 to 21 periods.
 // - Both clock loss bits read 1 just after reset, then clear.
 // - One-second flag sets each second, timed by the selected line clock.
 // - Writing 1 clears one-second flag; it waits for the next second.
 // - Overflow flag sets on overflow rise, clears on write of 1.
 // - Transmit clock loss flag sets on its rise, clears on write 1.
 // - Receive clock loss flag sets on its rise, clears on write 1.
 // - A latched flag raises the interrupt only while its enable is set.
 // - Enable bits pass their source when 1, block at 0, reset to 0.
 // - Clock select 0 times the second from receive, 1 from transmit clock.
 // - Enable bits 4 to 7: alarm code, framer alarm, tx loss, rx loss.
 // - Global summary bit for this framer follows its interrupt output.
*/
`ifndef FMSI_MAP_SVH
`define FMSI_MAP_SVH

`define FMSI_ADDR_STATUS   8'h08
`define FMSI_ADDR_LATCHED  8'h09
`define FMSI_ADDR_ENABLE   8'h0A

`define FMSI_BIT_OST       0
`define FMSI_BIT_COUNTER_OVERFLOW      1
`define FMSI_BIT_TESTER    2
`define FMSI_BIT_DATALINK  3
`define FMSI_BIT_ALARMCODE 4
`define FMSI_BIT_FRAMER    5
`define FMSI_BIT_TXLOSS    6
`define FMSI_BIT_RXLOSS    7

`define FMSI_ENABLE_RESET  8'h00
`define FMSI_LATCHED_RESET 8'h00
`define FMSI_STATUS_RESET  8'hC0
`define FMSI_SUMMARY_MASK  8'h3C
`define FMSI_FLAG_MASK     8'hC3
`define FMSI_UNMAPPED_READ 8'h00

`define FMSI_SUB_BLOCKS    4
`define FMSI_LOSS_LIMIT    15
`define FMSI_ONE_SEC_EDGES 1000000

`endif

// ### shared/fmsi_pkg.sv
/*
 Types of the framer master status and interrupt block.
 Assumes the constant header is found on the include path.
*/
`include "fmsi_map.svh"

package fmsi_pkg;

   typedef logic [7:0] fmsi_byte_t;

   typedef enum logic [1:0] {
      FMSI_SEL_NONE    = 2'b00,
      FMSI_SEL_STATUS  = 2'b01,
      FMSI_SEL_LATCHED = 2'b11,
      FMSI_SEL_ENABLE  = 2'b10
   } fmsi_reg_sel_t;

endpackage : fmsi_pkg

// ### rtl/fmsi_clk_mon.sv
/*
 Loss-of-clock monitor for one line clock, checked with the system clock.
 Assumes the monitored clock is sampled synchronously and runs below half
 the system clock rate.
*/
`timescale 1ns/1ps
`include "fmsi_map.svh"

module fmsi_clk_mon #(
   parameter int LIMIT = `FMSI_LOSS_LIMIT
) (
   input  wire logic clk_in,
   input  wire logic srst_in,
   input  wire logic mon_clk_in,
   output logic      loss_out,
   output logic      rise_out
);

   logic       sample_reg;
   logic       sample_next;
   logic [4:0] count_reg;
   logic [4:0] count_next;
   logic       loss_reg;
   logic       loss_next;
   logic       rise_reg;
   logic       rise_next;
   logic       toggle;

   assign toggle = mon_clk_in != sample_reg;

   always_comb begin
      sample_next = mon_clk_in;
      rise_next   = mon_clk_in & ~sample_reg;
      count_next  = count_reg;
      loss_next   = loss_reg;
      if (toggle) begin
         count_next = 5'h00;
         loss_next  = 1'b0;
      end else if (count_reg == 5'(LIMIT - 1)) begin
         loss_next = 1'b1;
      end else begin
         count_next = count_reg + 5'h01;
      end
   end

   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         sample_reg <= 1'b0;
         count_reg  <= 5'h00;
         loss_reg   <= 1'b1;
         rise_reg   <= 1'b0;
      end else begin
         sample_reg <= sample_next;
         count_reg  <= count_next;
         loss_reg   <= loss_next;
         rise_reg   <= rise_next;
      end
   end

   assign loss_out = loss_reg;
   assign rise_out = rise_reg;

   default clocking cb @(posedge clk_in); endclocking
   default disable iff (srst_in);

   a_loss_after_rst: assert property ($past(srst_in) |-> loss_out)
      else $error("clock loss not set right after reset");
   a_loss_on_stall: assert property (
      !toggle [*8] ##1 !toggle [*8] |=> loss_out)
      else $error("clock loss missing after stalled clock");
   a_loss_clears: assert property (toggle |=> !loss_out)
      else $error("clock loss not cleared on toggle");

endmodule : fmsi_clk_mon

// ### rtl/fmsi_sec_timer.sv
/*
 One-second timer counting rising edges of the selected reference clock.
 Assumes edge_in is a one-cycle pulse per reference rising edge.
*/
`timescale 1ns/1ps
`include "fmsi_map.svh"

module fmsi_sec_timer #(
   parameter int EDGES = `FMSI_ONE_SEC_EDGES
) (
   input  wire logic clk_in,
   input  wire logic srst_in,
   input  wire logic edge_in,
   output logic      tick_out
);

   logic [31:0] count_reg;
   logic [31:0] count_next;
   logic        tick_reg;
   logic        tick_next;

   always_comb begin
      count_next = count_reg;
      tick_next  = 1'b0;
      if (edge_in) begin
         if (count_reg == 32'(EDGES - 1)) begin
            count_next = 32'h0000_0000;
            tick_next  = 1'b1;
         end else begin
            count_next = count_reg + 32'h0000_0001;
         end
      end
   end

   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         count_reg <= 32'h0000_0000;
         tick_reg  <= 1'b0;
      end else begin
         count_reg <= count_next;
         tick_reg  <= tick_next;
      end
   end

   assign tick_out = tick_reg;

   default clocking cb @(posedge clk_in); endclocking
   default disable iff (srst_in);

   a_tick_at_wrap: assert property (
      tick_out |-> $past(edge_in) && count_reg == 32'h0000_0000)
      else $error("tick without counter wrap");

endmodule : fmsi_sec_timer

// ### rtl/fmsi_top.sv
/*
 Framer master status, latched status and interrupt enable registers with
 the framer interrupt request. Assumes a synchronous 8-bit register port,
 sub-block latched status and enables supplied by their own blocks, and
 line clocks sampled synchronously to the system clock.
*/
`timescale 1ns/1ps
`include "fmsi_map.svh"

module fmsi_top #(
   parameter int LOSS_LIMIT    = `FMSI_LOSS_LIMIT,
   parameter int ONE_SEC_EDGES = `FMSI_ONE_SEC_EDGES
) (
   input  wire logic               clk_in,
   input  wire logic               srst_in,
   input  wire logic [7:0]         addr_in,
   input  wire logic               wr_en_in,
   input  wire logic               rd_en_in,
   input  wire fmsi_pkg::fmsi_byte_t wdata_in,
   output fmsi_pkg::fmsi_byte_t    rdata_out,
   input  wire logic               counter_saturated_in,
   input  wire logic               counters_clear_in,
   input  wire logic [7:0]         tester_latched_status_in,
   input  wire logic [7:0]         tester_status_enable_in,
   input  wire logic [7:0]         datalink_latched_status_in,
   input  wire logic [7:0]         datalink_status_enable_in,
   input  wire logic [7:0]         alarm_code_latched_status_in,
   input  wire logic [7:0]         alarm_code_status_enable_in,
   input  wire logic [7:0]         framer_latched_status_in,
   input  wire logic [7:0]         framer_status_enable_in,
   input  wire logic               tx_input_clock_in,
   input  wire logic               rx_line_clock_in,
   input  wire logic               one_second_clock_select_in,
   output logic                    irq_out,
   output logic                    one_second_tick_out
);

   function automatic fmsi_pkg::fmsi_reg_sel_t decode(
      input logic [7:0] addr);
      fmsi_pkg::fmsi_reg_sel_t sel;
      sel = fmsi_pkg::FMSI_SEL_NONE;
      if (addr == `FMSI_ADDR_STATUS) begin
         sel = fmsi_pkg::FMSI_SEL_STATUS;
      end else if (addr == `FMSI_ADDR_LATCHED) begin
         sel = fmsi_pkg::FMSI_SEL_LATCHED;
      end else if (addr == `FMSI_ADDR_ENABLE) begin
         sel = fmsi_pkg::FMSI_SEL_ENABLE;
      end
      return sel;
   endfunction : decode

   function automatic logic any_enabled(input logic [7:0] lat,
                                        input logic [7:0] en);
      return |(lat & en);
   endfunction : any_enabled

   fmsi_pkg::fmsi_byte_t master_status_reg;
   fmsi_pkg::fmsi_byte_t master_status_next;
   fmsi_pkg::fmsi_byte_t status_prev_reg;
   fmsi_pkg::fmsi_byte_t status_prev_next;
   fmsi_pkg::fmsi_byte_t master_status_latched_reg;
   fmsi_pkg::fmsi_byte_t master_status_latched_next;
   fmsi_pkg::fmsi_byte_t master_interrupt_enable_reg;
   fmsi_pkg::fmsi_byte_t master_interrupt_enable_next;
   fmsi_pkg::fmsi_byte_t rdata_reg;
   fmsi_pkg::fmsi_byte_t rdata_next;
   logic                 irq_reg;
   logic                 irq_next;
   logic                 tick_reg;
   logic                 tick_next;

   logic [`FMSI_SUB_BLOCKS-1:0][7:0] sub_latched;
   logic [`FMSI_SUB_BLOCKS-1:0][7:0] sub_enable;
   logic [`FMSI_SUB_BLOCKS-1:0]      sub_summary;
   logic                 tx_clock_loss;
   logic                 rx_clock_loss;
   logic                 tx_rise;
   logic                 rx_rise;
   logic                 ref_edge;
   logic                 one_second_tick;
   fmsi_pkg::fmsi_reg_sel_t sel;
   logic                 wr_latched;
   logic                 wr_enable;

   assign sub_latched = {framer_latched_status_in,
                         alarm_code_latched_status_in,
                         datalink_latched_status_in,
                         tester_latched_status_in};
   assign sub_enable  = {framer_status_enable_in,
                         alarm_code_status_enable_in,
                         datalink_status_enable_in,
                         tester_status_enable_in};

   // Tester, data link, alarm code and framer summaries in that order
   generate
      for (genvar i = 0; i < `FMSI_SUB_BLOCKS; i++) begin : g_sub
         assign sub_summary[i] = any_enabled(sub_latched[i],
                                             sub_enable[i]);
      end
   endgenerate

   fmsi_clk_mon #(
      .LIMIT      (LOSS_LIMIT)
   ) u_tx_mon (
      .clk_in     (clk_in),
      .srst_in    (srst_in),
      .mon_clk_in (tx_input_clock_in),
      .loss_out   (tx_clock_loss),
      .rise_out   (tx_rise)
   );

   fmsi_clk_mon #(
      .LIMIT      (LOSS_LIMIT)
   ) u_rx_mon (
      .clk_in     (clk_in),
      .srst_in    (srst_in),
      .mon_clk_in (rx_line_clock_in),
      .loss_out   (rx_clock_loss),
      .rise_out   (rx_rise)
   );

   // Reference edge for the one-second timer
   assign ref_edge = one_second_clock_select_in ? tx_rise : rx_rise;

   fmsi_sec_timer #(
      .EDGES    (ONE_SEC_EDGES)
   ) u_sec (
      .clk_in   (clk_in),
      .srst_in  (srst_in),
      .edge_in  (ref_edge),
      .tick_out (one_second_tick)
   );

   assign sel        = decode(addr_in);
   assign wr_latched = wr_en_in && sel == fmsi_pkg::FMSI_SEL_LATCHED;
   assign wr_enable  = wr_en_in && sel == fmsi_pkg::FMSI_SEL_ENABLE;

   // Status and latched flags
   always_comb begin
      master_status_next = 8'h00;
      master_status_next[`FMSI_BIT_COUNTER_OVERFLOW] = counter_saturated_in |
         (master_status_reg[`FMSI_BIT_COUNTER_OVERFLOW] & ~counters_clear_in);
      master_status_next[`FMSI_BIT_FRAMER:`FMSI_BIT_TESTER] =
         sub_summary;
      master_status_next[`FMSI_BIT_TXLOSS] = tx_clock_loss;
      master_status_next[`FMSI_BIT_RXLOSS] = rx_clock_loss;
      status_prev_next = master_status_reg;

      master_status_latched_next = master_status_latched_reg;
      if (wr_latched) begin
         master_status_latched_next = master_status_latched_reg &
            ~(wdata_in & `FMSI_FLAG_MASK);
      end
      // Set wins over a clear in the same cycle
      if (one_second_tick) begin
         master_status_latched_next[`FMSI_BIT_OST] = 1'b1;
      end
      if (master_status_reg[`FMSI_BIT_COUNTER_OVERFLOW] &
          ~status_prev_reg[`FMSI_BIT_COUNTER_OVERFLOW]) begin
         master_status_latched_next[`FMSI_BIT_COUNTER_OVERFLOW] = 1'b1;
      end
      if (master_status_reg[`FMSI_BIT_TXLOSS] &
          ~status_prev_reg[`FMSI_BIT_TXLOSS]) begin
         master_status_latched_next[`FMSI_BIT_TXLOSS] = 1'b1;
      end
      if (master_status_reg[`FMSI_BIT_RXLOSS] &
          ~status_prev_reg[`FMSI_BIT_RXLOSS]) begin
         master_status_latched_next[`FMSI_BIT_RXLOSS] = 1'b1;
      end
   end

   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         master_status_reg         <= `FMSI_STATUS_RESET;
         status_prev_reg           <= `FMSI_STATUS_RESET;
         master_status_latched_reg <= `FMSI_LATCHED_RESET;
      end else begin
         master_status_reg         <= master_status_next;
         status_prev_reg           <= status_prev_next;
         master_status_latched_reg <= master_status_latched_next;
      end
   end

   // Register port, enables and interrupt request
   always_comb begin
      master_interrupt_enable_next = master_interrupt_enable_reg;
      if (wr_enable) begin
         master_interrupt_enable_next = wdata_in;
      end
      rdata_next = rdata_reg;
      if (rd_en_in) begin
         unique case (sel)
            fmsi_pkg::FMSI_SEL_NONE:    rdata_next = `FMSI_UNMAPPED_READ;
            fmsi_pkg::FMSI_SEL_STATUS:  rdata_next = master_status_reg;
            fmsi_pkg::FMSI_SEL_LATCHED: rdata_next =
               master_status_latched_reg;
            fmsi_pkg::FMSI_SEL_ENABLE:  rdata_next =
               master_interrupt_enable_reg;
         endcase
      end
      irq_next = |(master_status_reg & master_interrupt_enable_reg &
                   `FMSI_SUMMARY_MASK) |
                 |(master_status_latched_reg &
                   master_interrupt_enable_reg & `FMSI_FLAG_MASK);
      tick_next = one_second_tick;
   end

   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         master_interrupt_enable_reg <= `FMSI_ENABLE_RESET;
         rdata_reg                   <= `FMSI_UNMAPPED_READ;
         irq_reg                     <= 1'b0;
         tick_reg                    <= 1'b0;
      end else begin
         master_interrupt_enable_reg <= master_interrupt_enable_next;
         rdata_reg                   <= rdata_next;
         irq_reg                     <= irq_next;
         tick_reg                    <= tick_next;
      end
   end

   // Request toward the shared pin and the global summary bit
   assign irq_out             = irq_reg;
   assign rdata_out           = rdata_reg;
   assign one_second_tick_out = tick_reg;

   default clocking cb @(posedge clk_in); endclocking
   default disable iff (srst_in);

   a_counter_overflow_hold: assert property (
      counter_saturated_in |=> master_status_reg[`FMSI_BIT_COUNTER_OVERFLOW])
      else $error("overflow summary not held");
   a_counter_overflow_clear: assert property (
      counters_clear_in && !counter_saturated_in
      |=> !master_status_reg[`FMSI_BIT_COUNTER_OVERFLOW])
      else $error("overflow summary not cleared");
   a_tester_summary: assert property (
      ##1 master_status_reg[`FMSI_BIT_TESTER] ==
      $past(|(tester_latched_status_in & tester_status_enable_in)))
      else $error("tester summary mismatch");
   a_framer_summary_drop: assert property (
      framer_status_enable_in == 8'h00
      |=> !master_status_reg[`FMSI_BIT_FRAMER])
      else $error("framer summary not dropped");
   a_irq_blocked: assert property (
      master_interrupt_enable_reg == 8'h00 |=> !irq_out)
      else $error("interrupt with all enables clear");
   a_irq_summary: assert property (
      master_status_reg[`FMSI_BIT_DATALINK] &&
      master_interrupt_enable_reg[`FMSI_BIT_DATALINK] |=> irq_out)
      else $error("enabled summary gave no interrupt");
   a_irq_flag: assert property (
      master_status_latched_reg[`FMSI_BIT_OST] &&
      master_interrupt_enable_reg[`FMSI_BIT_OST] |=> irq_out)
      else $error("enabled flag gave no interrupt");
   a_irq_cause: assert property (
      irq_out |-> $past(|(master_interrupt_enable_reg &
         ((master_status_reg & `FMSI_SUMMARY_MASK) |
          (master_status_latched_reg & `FMSI_FLAG_MASK)))))
      else $error("interrupt without enabled source");
   a_ost_set: assert property (
      one_second_tick |=> master_status_latched_reg[`FMSI_BIT_OST])
      else $error("one-second flag not set");
   a_ost_w1c: assert property (
      wr_latched && wdata_in[`FMSI_BIT_OST] && !one_second_tick
      |=> !master_status_latched_reg[`FMSI_BIT_OST])
      else $error("one-second flag not cleared");
   a_txloss_flag: assert property (
      $rose(master_status_reg[`FMSI_BIT_TXLOSS])
      |=> master_status_latched_reg[`FMSI_BIT_TXLOSS])
      else $error("tx clock loss flag not set");
   a_rxloss_flag: assert property (
      $rose(master_status_reg[`FMSI_BIT_RXLOSS])
      |=> master_status_latched_reg[`FMSI_BIT_RXLOSS])
      else $error("rx clock loss flag not set");
   a_counter_overflow_flag_stays: assert property (
      $fell(master_status_latched_reg[`FMSI_BIT_COUNTER_OVERFLOW])
      |-> $past(wr_latched && wdata_in[`FMSI_BIT_COUNTER_OVERFLOW]))
      else $error("overflow flag cleared without write");

   c_irq_rise: cover property ($rose(irq_out));
   c_tx_loss: cover property (
      $rose(master_status_latched_reg[`FMSI_BIT_TXLOSS]));
   c_one_second: cover property (one_second_tick_out);

endmodule : fmsi_top

// ### bench/fmsi_line_src.sv
/*
 Line clock source for the transmit and receive line clocks.
 Assumes the run controls change at system clock edges.
*/
`timescale 1ns/1ps

module fmsi_line_src (
   input  wire logic clk_in,
   input  wire logic tx_run_in,
   input  wire logic rx_run_in,
   output logic      tx_clk_out,
   output logic      rx_clk_out
);
   logic phase_reg;

   initial begin
      phase_reg  = 1'b0;
      tx_clk_out = 1'b0;
      rx_clk_out = 1'b0;
   end

   // Toggles every second edge: 25 MHz, below the sampling limit.
   // A stopped clock freezes at its level, as a lost line clock does.
   always @(posedge clk_in) begin
      phase_reg <= ~phase_reg;
      if (phase_reg) begin
         if (tx_run_in) tx_clk_out <= ~tx_clk_out;
         if (rx_run_in) rx_clk_out <= ~rx_clk_out;
      end
   end
endmodule : fmsi_line_src

// ### bench/tb_top.sv
/*
 Self-checking bench of the framer master status and interrupt block.
 Assumes the line clock source and the design files are compiled first.
*/
`timescale 1ns/1ps
`include "fmsi_map.svh"

module tb_top;
   logic                 clk_in;
   logic                 srst_in;
   logic [7:0]           addr_in;
   logic                 wr_en_in;
   logic                 rd_en_in;
   fmsi_pkg::fmsi_byte_t wdata_in;
   fmsi_pkg::fmsi_byte_t rdata_out;
   logic                 sat_in;
   logic                 clr_in;
   logic [7:0]           lat [4];
   logic [7:0]           en [4];
   logic                 tx_clk;
   logic                 rx_clk;
   logic                 tx_run;
   logic                 rx_run;
   logic                 sel_in;
   logic                 irq_out;
   logic                 tick_out;
   int                   miscompares;
   int                   checks_done;
   int                   cycles;
   int                   k;

   fmsi_top #(.ONE_SEC_EDGES(8)) uut (
      .clk_in(clk_in), .srst_in(srst_in), .addr_in(addr_in),
      .wr_en_in(wr_en_in), .rd_en_in(rd_en_in), .wdata_in(wdata_in),
      .rdata_out(rdata_out), .counter_saturated_in(sat_in),
      .counters_clear_in(clr_in),
      .tester_latched_status_in(lat[0]), .tester_status_enable_in(en[0]),
      .datalink_latched_status_in(lat[1]),
      .datalink_status_enable_in(en[1]),
      .alarm_code_latched_status_in(lat[2]),
      .alarm_code_status_enable_in(en[2]),
      .framer_latched_status_in(lat[3]), .framer_status_enable_in(en[3]),
      .tx_input_clock_in(tx_clk), .rx_line_clock_in(rx_clk),
      .one_second_clock_select_in(sel_in), .irq_out(irq_out),
      .one_second_tick_out(tick_out));

   fmsi_line_src src (.clk_in(clk_in), .tx_run_in(tx_run),
      .rx_run_in(rx_run), .tx_clk_out(tx_clk), .rx_clk_out(rx_clk));

   initial begin
      clk_in = 1'b0;
      forever #5 clk_in = ~clk_in;
   end

   task automatic print_verdict();
      $display("checks %0d mismatches %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : print_verdict

   task automatic check8(input fmsi_pkg::fmsi_byte_t got,
                         input fmsi_pkg::fmsi_byte_t exp);
      checks_done++;
      if (got !== exp) begin
         miscompares++;
         $display("unexpected at %0t: read %h want %h", $time, got, exp);
      end
   endtask : check8

   task automatic check1(input logic got, input logic exp);
      checks_done++;
      if (got !== exp) begin
         miscompares++;
         $display("unexpected at %0t: flag %b want %b", $time, got, exp);
      end
   endtask : check1

   task automatic cyc(input int n);
      repeat (n) @(posedge clk_in);
   endtask : cyc

   task automatic wr(input logic [7:0] a, input fmsi_pkg::fmsi_byte_t d);
      @(posedge clk_in);
      addr_in  <= a;
      wdata_in <= d;
      wr_en_in <= 1'b1;
      @(posedge clk_in);
      wr_en_in <= 1'b0;
   endtask : wr

   // Mask hides bits that run on their own during the test
   task automatic rd_chk(input logic [7:0] a,
                         input fmsi_pkg::fmsi_byte_t exp,
                         input fmsi_pkg::fmsi_byte_t m = 8'hFF);
      @(posedge clk_in);
      addr_in  <= a;
      rd_en_in <= 1'b1;
      @(posedge clk_in);
      rd_en_in <= 1'b0;
      @(posedge clk_in);
      #1;
      check8(rdata_out & m, exp);
   endtask : rd_chk

   task automatic irq_chk(input logic exp);
      cyc(2);
      #1;
      check1(irq_out, exp);
   endtask : irq_chk

   task automatic sub(input int i, input logic [7:0] l, input logic [7:0] e);
      @(posedge clk_in);
      lat[i] <= l;
      en[i]  <= e;
   endtask : sub

   task automatic wait_tick();
      int n;
      n = 0;
      while (tick_out !== 1'b1 && n < 200) begin
         @(posedge clk_in);
         #1;
         n++;
      end
      check1(tick_out, 1'b1);
   endtask : wait_tick

   always @(posedge clk_in) begin
      cycles++;
      if (cycles == 6000) begin
         miscompares++;
         $display("unexpected at %0t: run too long", $time);
         print_verdict();
      end
   end

   initial begin
      srst_in = 1'b1;
      addr_in = 8'h00;
      wr_en_in = 1'b0;
      rd_en_in = 1'b0;
      wdata_in = 8'h00;
      sat_in = 1'b0;
      clr_in = 1'b0;
      sel_in = 1'b0;
      tx_run = 1'b0;
      rx_run = 1'b0;
      for (k = 0; k < 4; k++) begin
         lat[k] = 8'h00;
         en[k] = 8'h00;
      end
      miscompares = 0;
      checks_done = 0;
      cycles = 0;
      cyc(2);
      srst_in <= 1'b0;
      rd_chk(`FMSI_ADDR_STATUS, 8'hC0);
      rd_chk(`FMSI_ADDR_LATCHED, 8'h00);
      rd_chk(`FMSI_ADDR_ENABLE, 8'h00);
      rd_chk(8'h3F, 8'h00);
      tx_run <= 1'b1;
      rx_run <= 1'b1;
      cyc(10);
      rd_chk(`FMSI_ADDR_STATUS, 8'h00);
      wr(`FMSI_ADDR_STATUS, 8'hFF);
      rd_chk(`FMSI_ADDR_STATUS, 8'h00);
      wr(`FMSI_ADDR_ENABLE, 8'hA5);
      rd_chk(`FMSI_ADDR_ENABLE, 8'hA5);
      wr(`FMSI_ADDR_ENABLE, 8'h00);
      // Sub-block summaries, each gated by latched bits and enables
      for (k = 0; k < 4; k++) begin
         sub(k, 8'h81, 8'h02);
         rd_chk(`FMSI_ADDR_STATUS, 8'h00);
         sub(k, 8'h81, 8'h80);
         rd_chk(`FMSI_ADDR_STATUS, 8'h04 << k);
         irq_chk(1'b0);
         wr(`FMSI_ADDR_ENABLE, 8'h04 << k);
         irq_chk(1'b1);
         sub(k, 8'h00, 8'h80);
         rd_chk(`FMSI_ADDR_STATUS, 8'h00);
         irq_chk(1'b0);
         sub(k, 8'h81, 8'h80);
         irq_chk(1'b1);
         sub(k, 8'h81, 8'h00);
         irq_chk(1'b0);
         sub(k, 8'h81, 8'h80);
         wr(`FMSI_ADDR_ENABLE, 8'h00);
         irq_chk(1'b0);
         sub(k, 8'h00, 8'h00);
      end
      // Counter overflow summary and its latched flag
      wr(`FMSI_ADDR_ENABLE, 8'h02);
      @(posedge clk_in);
      sat_in <= 1'b1;
      rd_chk(`FMSI_ADDR_STATUS, 8'h02);
      rd_chk(`FMSI_ADDR_LATCHED, 8'h02, 8'hFE);
      irq_chk(1'b1);
      wr(`FMSI_ADDR_LATCHED, 8'h02);
      rd_chk(`FMSI_ADDR_LATCHED, 8'h00, 8'hFE);
      irq_chk(1'b0);
      rd_chk(`FMSI_ADDR_STATUS, 8'h02);
      @(posedge clk_in);
      sat_in <= 1'b0;
      clr_in <= 1'b1;
      @(posedge clk_in);
      clr_in <= 1'b0;
      rd_chk(`FMSI_ADDR_STATUS, 8'h00);
      @(posedge clk_in);
      sat_in <= 1'b1;
      // Flag lands two edges after the input, one more than a read needs
      cyc(1);
      rd_chk(`FMSI_ADDR_LATCHED, 8'h02, 8'hFE);
      @(posedge clk_in);
      sat_in <= 1'b0;
      clr_in <= 1'b1;
      @(posedge clk_in);
      clr_in <= 1'b0;
      wr(`FMSI_ADDR_LATCHED, 8'h02);
      // Clock loss: k 0 is the transmit clock, k 1 the receive clock
      for (k = 0; k < 2; k++) begin
         wr(`FMSI_ADDR_ENABLE, 8'h40 << k);
         @(posedge clk_in);
         if (k == 0) tx_run <= 1'b0;
         else rx_run <= 1'b0;
         rd_chk(`FMSI_ADDR_STATUS, 8'h00);
         irq_chk(1'b0);
         cyc(20);
         rd_chk(`FMSI_ADDR_STATUS, 8'h40 << k);
         rd_chk(`FMSI_ADDR_LATCHED, 8'h40 << k, 8'hFE);
         irq_chk(1'b1);
         @(posedge clk_in);
         tx_run <= 1'b1;
         rx_run <= 1'b1;
         cyc(4);
         rd_chk(`FMSI_ADDR_STATUS, 8'h00);
         rd_chk(`FMSI_ADDR_LATCHED, 8'h40 << k, 8'hFE);
         wr(`FMSI_ADDR_LATCHED, 8'h40 << k);
         rd_chk(`FMSI_ADDR_LATCHED, 8'h00, 8'hFE);
         irq_chk(1'b0);
      end
      // One-second flag, first from the receive clock
      wr(`FMSI_ADDR_ENABLE, 8'h01);
      wr(`FMSI_ADDR_LATCHED, 8'h01);
      wait_tick();
      // Host sees the request first, then reads the latched flags
      irq_chk(1'b1);
      rd_chk(`FMSI_ADDR_LATCHED, 8'h01, 8'h01);
      wr(`FMSI_ADDR_LATCHED, 8'h01);
      rd_chk(`FMSI_ADDR_LATCHED, 8'h00, 8'h01);
      irq_chk(1'b0);
      @(posedge clk_in);
      rx_run <= 1'b0;
      cyc(4);
      wr(`FMSI_ADDR_LATCHED, 8'h01);
      cyc(100);
      rd_chk(`FMSI_ADDR_LATCHED, 8'h00, 8'h01);
      @(posedge clk_in);
      sel_in <= 1'b1;
      wait_tick();
      cyc(2);
      rd_chk(`FMSI_ADDR_LATCHED, 8'h01, 8'h01);
      irq_chk(1'b1);
      wr(`FMSI_ADDR_ENABLE, 8'h00);
      irq_chk(1'b0);
      print_verdict();
   end
endmodule : tb_top
